/* File: rtl/pbcao_pkg.sv */
`default_nettype none
package pbcao_pkg;
   // spike filter: reject pulses shorter than this on two-wire inputs
   localparam int SPIKE_NS = 50;
   localparam int CLK_PERIOD_NS = 8;
   // shortest time rounds up to whole cycles
   localparam int SPIKE_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] PORT_RESET = 8'h00;
   // pin positions
   localparam int PB_SCK = 7;
   localparam int PB_MISO = 6;
   localparam int PB_MOSI = 5;
   localparam int PB_SSEL = 4;
   localparam int PB_CMP0 = 3;
   localparam int PB_IRQ2 = 2;
   localparam int PB_CNT1 = 1;
   localparam int PB_XCLK = 0;
   localparam int PC_XOUT = 7;
   localparam int PC_XIN = 6;
   localparam int PC_TDI = 5;
   localparam int PC_TDO = 4;
   localparam int PC_TMS = 3;
   localparam int PC_TCK = 2;
   localparam int PC_SDA = 1;
   localparam int PC_SCL = 0;

   // per-port override bundle, one bit per pin
   typedef struct packed {
      logic [7:0] pull_up_override_enable;
      logic [7:0] pull_up_override_value;
      logic [7:0] direction_override_enable;
      logic [7:0] direction_override_value;
      logic [7:0] pin_value_override_enable;
      logic [7:0] pin_value_override_value;
      logic [7:0] input_buffer_override_enable;
      logic [7:0] input_buffer_override_value;
   } pbcao_ovr_s;

   // general-purpose port register view
   typedef struct packed {
      logic [7:0] data;
      logic [7:0] dir;
   } pbcao_port_s;
endpackage
`default_nettype wire

/* File: rtl/pbcao_spike.sv */
`default_nettype none
// glitch filter: output follows input only after it is stable SPIKE_CYC cycles
module pbcao_spike
(
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic en,
   input wire logic din,
   output logic dout
);
   localparam int CW = $clog2(pbcao_pkg::SPIKE_CYC + 1);
   localparam logic [CW-1:0] CMAX = CW'(pbcao_pkg::SPIKE_CYC);
   logic s1_reg;
   logic s2_reg;
   logic [CW-1:0] cnt_reg;

   // two-stage synchroniser
   always_ff @(posedge MCLK)
   begin
      if (!RSTN)
      begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
      end
      else
      begin
         s1_reg <= din;
         s2_reg <= s1_reg;
      end
   end

   // stability counter
   always_ff @(posedge MCLK)
   begin
      if (!RSTN)
      begin
         cnt_reg <= '0;
         dout <= 1'b1;
      end
      else if (!en || s2_reg == dout)
         cnt_reg <= '0;
      else if (cnt_reg == CMAX - 1'b1)
      begin
         cnt_reg <= '0;
         dout <= s2_reg;
      end
      else
         cnt_reg <= cnt_reg + 1'b1;
   end

   a_spike_reject: assert property (@(posedge MCLK) disable iff (!RSTN)
      $changed(dout) |-> $past(s2_reg, 1) == dout && $past(s2_reg, 6) == dout) // R15
      else $error("spike filter passed a short pulse");
endmodule
`default_nettype wire

/* File: rtl/pbcao_top.sv */
`default_nettype none
// Behaviour
// R1 - spi pins: pull-up/direction override on spi enable, miso when master, sck/mosi/ssel when slave; direction value 0
// R2 - miso carries master input and slave output; mosi the opposite
// R3 - spi pull-up value is port data bit gated by pull-up disable
// R4 - pb0 value override on usart sync select; input feeds usart clock and counter0
// R5 - usart clock pin active only in sync mode; direction bit selects role
// R6 - pb3 driven by compare output when enabled; pb1 feeds counter1 input
// R7 - irq2 enable forces pb2 input buffer on; pin feeds irq2
// R8 - async timer clock takes pc7/pc6 off port control, to crystal amplifier
// R9 - test port enable overrides four test pins; pull-ups 1,0,1,1; inputs off
// R10 - test port pull-ups stay on during device reset
// R11 - tdo driven only in shift states; direction value is or of both
// R12 - test port timing comes only from test clock, set by outside party
// R13 - two-wire enable: pc1/pc0 open drain, value 0, direction from pull-low
// R14 - two-wire pull-ups follow port data bit gated by pull-up disable
// R15 - two-wire inputs reject pulses shorter than 50 ns
// R16 - value override enable replaces port data bit with override value
// R17 - input buffer override decides buffer enable, else sleep state decides
// R18 - global pull-up disable turns all pull-ups off; test port pull-ups (pc5, pc3, pc2) stay on while TEST_PORT_ENABLE is set
// R19 - pull-up and direction overrides replace port-derived values
// R20 - overrides are combinational from peripheral enables
module pbcao_top
(
   input wire logic MCLK,
   input wire logic RSTN,
   input wire pbcao_pkg::pbcao_port_s PORTB_REGS,
   input wire pbcao_pkg::pbcao_port_s PORTC_REGS,
   input wire logic GLOBAL_PULLUP_OFF,
   input wire logic SLEEP_INPUT_OFF,
   input wire logic SERIAL_PERIPH_ON,
   input wire logic MASTER_ROLE_BIT,
   input wire logic SPI_SCK_OUT,
   input wire logic SPI_MASTER_OUT,
   input wire logic SPI_SLAVE_OUT,
   input wire logic USART_SYNC_SELECT,
   input wire logic USART_SYNC_CLOCK_OUT,
   input wire logic COMPARE_OUT_ZERO_EN,
   input wire logic COMPARE_OUT_ZERO,
   input wire logic EXTERNAL_IRQ_TWO_EN,
   input wire logic ASYNC_TIMER2_CLOCK,
   input wire logic TEST_PORT_ENABLE,
   input wire logic TAP_INSTR_SHIFTING,
   input wire logic TAP_DATA_SHIFTING,
   input wire logic TEST_PORT_SERIAL_OUT,
   input wire logic TWO_WIRE_ENABLE,
   input wire logic SDA_PULL_LOW,
   input wire logic SCL_PULL_LOW,
   input wire logic [7:0] PB_PAD_IN,
   input wire logic [7:0] PC_PAD_IN,
   output logic [7:0] PB_PAD_OUT,
   output logic [7:0] PB_PAD_OE_N,
   output logic [7:0] PB_PULLUP,
   output logic [7:0] PB_INPUT_EN,
   output logic [7:0] PC_PAD_OUT,
   output logic [7:0] PC_PAD_OE_N,
   output logic [7:0] PC_PULLUP,
   output logic [7:0] PC_INPUT_EN,
   output pbcao_pkg::pbcao_ovr_s PB_OVR,
   output pbcao_pkg::pbcao_ovr_s PC_OVR,
   output logic SPI_SCK_IN,
   output logic SPI_MASTER_IN,
   output logic SPI_SLAVE_IN,
   output logic SPI_SELECT_IN,
   output logic USART_SYNC_CLOCK_IN,
   output logic COUNTER_ZERO_EXT_INPUT,
   output logic COUNTER_ONE_EXT_INPUT,
   output logic EXTERNAL_IRQ_LINE_TWO,
   output logic SDA_TO_TWI,
   output logic SCL_TO_TWI
);
   pbcao_pkg::pbcao_ovr_s ob;
   pbcao_pkg::pbcao_ovr_s oc;
   logic spi_master;
   logic spi_slave;
   logic [7:0] pb_sync1_reg;
   logic [7:0] pb_sync2_reg;
   logic [7:0] pb_func_tap;

   assign spi_master = SERIAL_PERIPH_ON & MASTER_ROLE_BIT;
   assign spi_slave = SERIAL_PERIPH_ON & ~MASTER_ROLE_BIT;

   // port b override table
   always_comb
   begin
      ob = '0;
      for (int i = pbcao_pkg::PB_SSEL; i <= pbcao_pkg::PB_SCK; i++)
      begin
         ob.pull_up_override_enable[i] = (i == pbcao_pkg::PB_MISO) ? spi_master : spi_slave; // R1
         ob.pull_up_override_value[i] = PORTB_REGS.data[i] & ~GLOBAL_PULLUP_OFF; // R3
         ob.direction_override_enable[i] = ob.pull_up_override_enable[i]; // R1
         ob.direction_override_value[i] = 1'b0; // R1
      end
      ob.pin_value_override_enable[pbcao_pkg::PB_SCK] = spi_master; // R1
      ob.pin_value_override_enable[pbcao_pkg::PB_MISO] = spi_slave; // R2
      ob.pin_value_override_enable[pbcao_pkg::PB_MOSI] = spi_master; // R2
      ob.pin_value_override_value[pbcao_pkg::PB_SCK] = SPI_SCK_OUT;
      ob.pin_value_override_value[pbcao_pkg::PB_MISO] = SPI_SLAVE_OUT; // R2
      ob.pin_value_override_value[pbcao_pkg::PB_MOSI] = SPI_MASTER_OUT; // R2
      ob.pin_value_override_enable[pbcao_pkg::PB_CMP0] = COMPARE_OUT_ZERO_EN; // R6
      ob.pin_value_override_value[pbcao_pkg::PB_CMP0] = COMPARE_OUT_ZERO; // R6
      ob.input_buffer_override_enable[pbcao_pkg::PB_IRQ2] = EXTERNAL_IRQ_TWO_EN; // R7
      ob.input_buffer_override_value[pbcao_pkg::PB_IRQ2] = 1'b1; // R7
      ob.pin_value_override_enable[pbcao_pkg::PB_XCLK] = USART_SYNC_SELECT; // R4 R5
      ob.pin_value_override_value[pbcao_pkg::PB_XCLK] = USART_SYNC_CLOCK_OUT; // R4
   end

   // port c override table
   always_comb
   begin
      oc = '0;
      for (int i = pbcao_pkg::PC_XIN; i <= pbcao_pkg::PC_XOUT; i++)
      begin
         oc.pull_up_override_enable[i] = ASYNC_TIMER2_CLOCK; // R8
         oc.direction_override_enable[i] = ASYNC_TIMER2_CLOCK; // R8
         oc.input_buffer_override_enable[i] = ASYNC_TIMER2_CLOCK; // R8
      end
      for (int i = pbcao_pkg::PC_TCK; i <= pbcao_pkg::PC_TDI; i++)
      begin
         oc.pull_up_override_enable[i] = TEST_PORT_ENABLE; // R9
         oc.pull_up_override_value[i] = (i != pbcao_pkg::PC_TDO); // R9
         oc.direction_override_enable[i] = TEST_PORT_ENABLE; // R9
         oc.input_buffer_override_enable[i] = TEST_PORT_ENABLE; // R9
      end
      oc.direction_override_value[pbcao_pkg::PC_TDO] = TAP_INSTR_SHIFTING | TAP_DATA_SHIFTING; // R11
      oc.pin_value_override_enable[pbcao_pkg::PC_TDO] = TEST_PORT_ENABLE; // R11
      oc.pin_value_override_value[pbcao_pkg::PC_TDO] = TEST_PORT_SERIAL_OUT; // R11
      for (int i = pbcao_pkg::PC_SCL; i <= pbcao_pkg::PC_SDA; i++)
      begin
         oc.pull_up_override_enable[i] = TWO_WIRE_ENABLE; // R13
         oc.pull_up_override_value[i] = PORTC_REGS.data[i] & ~GLOBAL_PULLUP_OFF; // R14
         oc.direction_override_enable[i] = TWO_WIRE_ENABLE; // R13
         oc.pin_value_override_enable[i] = TWO_WIRE_ENABLE; // R13
      end
      oc.direction_override_value[pbcao_pkg::PC_SDA] = SDA_PULL_LOW; // R13
      oc.direction_override_value[pbcao_pkg::PC_SCL] = SCL_PULL_LOW; // R13
   end

   assign PB_OVR = ob; // R20
   assign PC_OVR = oc; // R20

   // final pin resolution per bit
   // pull-ups are combinational so a test port pull-up holds while RSTN is low
   generate
      for (genvar g = 0; g < 8; g++)
      begin : g_pin
         logic b_dir;
         logic c_dir;
         assign b_dir = ob.direction_override_enable[g] ?
                        ob.direction_override_value[g] : PORTB_REGS.dir[g]; // R19
         assign c_dir = oc.direction_override_enable[g] ?
                        oc.direction_override_value[g] : PORTC_REGS.dir[g]; // R19
         assign PB_PAD_OE_N[g] = ~b_dir;
         assign PC_PAD_OE_N[g] = ~c_dir; // R11
         assign PB_PAD_OUT[g] = ob.pin_value_override_enable[g] ?
                                ob.pin_value_override_value[g] : PORTB_REGS.data[g]; // R16
         assign PC_PAD_OUT[g] = oc.pin_value_override_enable[g] ?
                                oc.pin_value_override_value[g] : PORTC_REGS.data[g]; // R16
         assign PB_PULLUP[g] = ob.pull_up_override_enable[g] ? ob.pull_up_override_value[g] :
                               (~PORTB_REGS.dir[g] & PORTB_REGS.data[g] & ~GLOBAL_PULLUP_OFF); // R18
         assign PC_PULLUP[g] = oc.pull_up_override_enable[g] ? oc.pull_up_override_value[g] :
                               (~PORTC_REGS.dir[g] & PORTC_REGS.data[g] & ~GLOBAL_PULLUP_OFF); // R10
         assign PB_INPUT_EN[g] = ob.input_buffer_override_enable[g] ?
                                 ob.input_buffer_override_value[g] : ~SLEEP_INPUT_OFF; // R17
         assign PC_INPUT_EN[g] = oc.input_buffer_override_enable[g] ?
                                 oc.input_buffer_override_value[g] : ~SLEEP_INPUT_OFF; // R17
         assign pb_func_tap[g] = pb_sync2_reg[g] & PB_INPUT_EN[g];
      end
   endgenerate

   // port b pad inputs pass two flops before function logic
   always_ff @(posedge MCLK)
   begin
      if (!RSTN)
      begin
         pb_sync1_reg <= pbcao_pkg::PORT_RESET;
         pb_sync2_reg <= pbcao_pkg::PORT_RESET;
      end
      else
      begin
         pb_sync1_reg <= PB_PAD_IN;
         pb_sync2_reg <= pb_sync1_reg;
      end
   end

   assign SPI_SCK_IN = pb_func_tap[pbcao_pkg::PB_SCK];
   assign SPI_MASTER_IN = pb_func_tap[pbcao_pkg::PB_MISO]; // R2
   assign SPI_SLAVE_IN = pb_func_tap[pbcao_pkg::PB_MOSI]; // R2
   assign SPI_SELECT_IN = pb_func_tap[pbcao_pkg::PB_SSEL]; // R1
   assign EXTERNAL_IRQ_LINE_TWO = pb_func_tap[pbcao_pkg::PB_IRQ2]; // R7
   assign COUNTER_ONE_EXT_INPUT = pb_func_tap[pbcao_pkg::PB_CNT1]; // R6
   assign COUNTER_ZERO_EXT_INPUT = pb_func_tap[pbcao_pkg::PB_XCLK]; // R4
   assign USART_SYNC_CLOCK_IN = pb_func_tap[pbcao_pkg::PB_XCLK] & USART_SYNC_SELECT; // R5

   pbcao_spike u_sda_filt
   (
      .MCLK(MCLK),
      .RSTN(RSTN),
      .en(TWO_WIRE_ENABLE),
      .din(PC_PAD_IN[pbcao_pkg::PC_SDA]),
      .dout(SDA_TO_TWI)
   ); // R15

   pbcao_spike u_scl_filt
   (
      .MCLK(MCLK),
      .RSTN(RSTN),
      .en(TWO_WIRE_ENABLE),
      .din(PC_PAD_IN[pbcao_pkg::PC_SCL]),
      .dout(SCL_TO_TWI)
   ); // R15

   a_spi_dir_input: assert property (@(posedge MCLK) disable iff (!RSTN)
      SERIAL_PERIPH_ON |-> (MASTER_ROLE_BIT ? PB_PAD_OE_N[6] :
      (PB_PAD_OE_N[7] && PB_PAD_OE_N[5] && PB_PAD_OE_N[4]))) // R1
      else $error("spi input pins not forced to input");
   a_miso_slave_out: assert property (@(posedge MCLK) disable iff (!RSTN)
      spi_slave |-> PB_PAD_OUT[pbcao_pkg::PB_MISO] == SPI_SLAVE_OUT) // R2
      else $error("miso not carrying slave output");
   a_spi_pullup_gate: assert property (@(posedge MCLK) disable iff (!RSTN)
      SERIAL_PERIPH_ON && GLOBAL_PULLUP_OFF |-> PB_PULLUP[7:4] == 4'h0) // R3
      else $error("spi pull-up not gated");
   a_usart_clk_out: assert property (@(posedge MCLK) disable iff (!RSTN)
      USART_SYNC_SELECT |-> PB_PAD_OUT[0] == USART_SYNC_CLOCK_OUT) // R4
      else $error("usart clock not on pb0");
   a_usart_clk_in: assert property (@(posedge MCLK) disable iff (!RSTN)
      !USART_SYNC_SELECT |-> !USART_SYNC_CLOCK_IN) // R5
      else $error("usart clock input active outside sync mode");
   a_cmp_out: assert property (@(posedge MCLK) disable iff (!RSTN)
      COMPARE_OUT_ZERO_EN |-> PB_PAD_OUT[3] == COMPARE_OUT_ZERO) // R6
      else $error("compare output not on pb3");
   a_irq2_buffer: assert property (@(posedge MCLK) disable iff (!RSTN)
      EXTERNAL_IRQ_TWO_EN |-> PB_INPUT_EN[2]) // R7
      else $error("irq2 input buffer off");
   a_crystal_free: assert property (@(posedge MCLK) disable iff (!RSTN)
      ASYNC_TIMER2_CLOCK |-> PC_PULLUP[7:6] == 2'h0 && PC_INPUT_EN[7:6] == 2'h0) // R8
      else $error("crystal pins still under port control");
   a_test_pullups: assert property (@(posedge MCLK)
      TEST_PORT_ENABLE |-> PC_PULLUP[5:2] == 4'hb && PC_INPUT_EN[5:2] == 4'h0) // R9 R10
      else $error("test port pull-ups wrong");
   a_tdo_tristate: assert property (@(posedge MCLK) disable iff (!RSTN)
      TEST_PORT_ENABLE && !TAP_INSTR_SHIFTING && !TAP_DATA_SHIFTING
      |-> PC_PAD_OE_N[4]) // R11
      else $error("tdo driven outside shift states");
   a_twi_open_drain: assert property (@(posedge MCLK) disable iff (!RSTN)
      TWO_WIRE_ENABLE |-> PC_PAD_OUT[1:0] == 2'h0 &&
      PC_PAD_OE_N[1] == !SDA_PULL_LOW) // R13
      else $error("two-wire pin not open drain");
   a_twi_pullup: assert property (@(posedge MCLK) disable iff (!RSTN)
      TWO_WIRE_ENABLE |-> PC_PULLUP[1] == (PORTC_REGS.data[1] & !GLOBAL_PULLUP_OFF)) // R14
      else $error("two-wire pull-up not from port data");
   a_pud_global: assert property (@(posedge MCLK) disable iff (!RSTN)
      GLOBAL_PULLUP_OFF && !TEST_PORT_ENABLE |-> PC_PULLUP == 8'h00 && PB_PULLUP == 8'h00) // R18
      else $error("pull-up on despite global disable");
endmodule
`default_nettype wire

/* File: verif/pbcao_periph.sv */
`default_nettype none
// peripheral-side model: spi, usart, timer, tap and two-wire outputs
module pbcao_periph
(
   input wire logic mclk,
   input wire logic rstn,
   output logic [9:0] outs
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] lfsr_reg;
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         lfsr_reg <= 16'hace1;
      end
      else
      begin
         lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      end
   end
   // tap shift states and serial out step once per test-clock tick, one per clock here
   assign outs = lfsr_reg[9:0] ^ lfsr_reg[15:6];
endmodule
`default_nettype wire

/* File: verif/tb.sv */
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic MCLK = 1'b0;
   logic RSTN = 1'b0;
   pbcao_pkg::pbcao_port_s PORTB_REGS = '0;
   pbcao_pkg::pbcao_port_s PORTC_REGS = '0;
   logic GLOBAL_PULLUP_OFF = 1'b1;
   logic SLEEP_INPUT_OFF = 1'b0;
   logic SERIAL_PERIPH_ON = 1'b0;
   logic MASTER_ROLE_BIT = 1'b0;
   logic USART_SYNC_SELECT = 1'b0;
   logic COMPARE_OUT_ZERO_EN = 1'b0;
   logic EXTERNAL_IRQ_TWO_EN = 1'b0;
   logic ASYNC_TIMER2_CLOCK = 1'b0;
   logic TEST_PORT_ENABLE = 1'b1;
   logic TWO_WIRE_ENABLE = 1'b0;
   logic [7:0] PB_PAD_IN = 8'hff;
   logic [7:0] PC_PAD_IN = 8'hff;
   wire logic [9:0] periph;
   wire logic [7:0] PB_PAD_OUT, PB_PAD_OE_N, PB_PULLUP, PB_INPUT_EN;
   wire logic [7:0] PC_PAD_OUT, PC_PAD_OE_N, PC_PULLUP, PC_INPUT_EN;
   wire logic SPI_SCK_IN, SPI_MASTER_IN, SPI_SLAVE_IN, SPI_SELECT_IN, USART_SYNC_CLOCK_IN;
   wire logic COUNTER_ZERO_EXT_INPUT, COUNTER_ONE_EXT_INPUT, EXTERNAL_IRQ_LINE_TWO;
   wire logic SDA_TO_TWI, SCL_TO_TWI;
   wire pbcao_pkg::pbcao_ovr_s pb_ovr;
   wire pbcao_pkg::pbcao_ovr_s pc_ovr;
   wire logic [31:0] pins_b = {PB_PAD_OUT, PB_PAD_OE_N, PB_PULLUP, PB_INPUT_EN};
   wire logic [31:0] pins_c = {PC_PAD_OUT, PC_PAD_OE_N, PC_PULLUP, PC_INPUT_EN};
   wire logic [7:0] taps = {SPI_SCK_IN, SPI_MASTER_IN, SPI_SLAVE_IN, SPI_SELECT_IN,
      EXTERNAL_IRQ_LINE_TWO, COUNTER_ONE_EXT_INPUT, COUNTER_ZERO_EXT_INPUT, USART_SYNC_CLOCK_IN};
   int num_errors = 0;
   int checks = 0;

   always #4 MCLK = ~MCLK;

   pbcao_top uut
   (
      .MCLK, .RSTN, .PORTB_REGS, .PORTC_REGS, .GLOBAL_PULLUP_OFF, .SLEEP_INPUT_OFF,
      .SERIAL_PERIPH_ON, .MASTER_ROLE_BIT, .SPI_SCK_OUT(periph[0]), .SPI_MASTER_OUT(periph[1]),
      .SPI_SLAVE_OUT(periph[2]), .USART_SYNC_SELECT, .USART_SYNC_CLOCK_OUT(periph[3]),
      .COMPARE_OUT_ZERO_EN, .COMPARE_OUT_ZERO(periph[4]), .EXTERNAL_IRQ_TWO_EN,
      .ASYNC_TIMER2_CLOCK, .TEST_PORT_ENABLE, .TAP_INSTR_SHIFTING(periph[5]),
      .TAP_DATA_SHIFTING(periph[6]), .TEST_PORT_SERIAL_OUT(periph[7]), .TWO_WIRE_ENABLE,
      .SDA_PULL_LOW(periph[8]), .SCL_PULL_LOW(periph[9]), .PB_PAD_IN, .PC_PAD_IN,
      .PB_PAD_OUT, .PB_PAD_OE_N, .PB_PULLUP, .PB_INPUT_EN, .PC_PAD_OUT, .PC_PAD_OE_N,
      .PC_PULLUP, .PC_INPUT_EN, .PB_OVR(pb_ovr), .PC_OVR(pc_ovr), .SPI_SCK_IN, .SPI_MASTER_IN,
      .SPI_SLAVE_IN, .SPI_SELECT_IN, .USART_SYNC_CLOCK_IN, .COUNTER_ZERO_EXT_INPUT,
      .COUNTER_ONE_EXT_INPUT, .EXTERNAL_IRQ_LINE_TWO, .SDA_TO_TWI, .SCL_TO_TWI
   );

   pbcao_periph partner
   (
      .mclk(MCLK),
      .rstn(RSTN),
      .outs(periph)
   );

   // expected {pull-up, value, input buffer} override enables of one port
   function automatic logic [23:0] expect_enables(input logic is_c);
      logic sm, ss, jt, a2, tw;
      logic [7:0] pu;
      sm = SERIAL_PERIPH_ON & MASTER_ROLE_BIT;
      ss = SERIAL_PERIPH_ON & ~MASTER_ROLE_BIT;
      jt = TEST_PORT_ENABLE;
      a2 = ASYNC_TIMER2_CLOCK;
      tw = TWO_WIRE_ENABLE;
      pu = is_c ? {a2, a2, jt, jt, jt, jt, tw, tw} : {ss, sm, ss, ss, 4'h0};
      if (is_c)
      begin
         return {pu, 3'b000, jt, 2'b00, tw, tw, pu[7:2], 2'b00};
      end
      return {pu, sm, ss, sm, 1'b0, COMPARE_OUT_ZERO_EN, 2'b00, USART_SYNC_SELECT, 5'h00,
         EXTERNAL_IRQ_TWO_EN, 2'b00};
   endfunction

   // observed {pull-up, direction, value, input buffer} override enables
   function automatic logic [31:0] got_enables(input pbcao_pkg::pbcao_ovr_s o);
      return {o.pull_up_override_enable, o.direction_override_enable,
         o.pin_value_override_enable, o.input_buffer_override_enable};
   endfunction

   // expected {out, oe_n, pull-up, input enable} of one port
   function automatic logic [31:0] expect_port(input logic is_c);
      logic [7:0] d, r, pu_en, pu_val, dir_val, val_en, val, ie_en, ie_val, dir, nopud;
      d = is_c ? PORTC_REGS.data : PORTB_REGS.data;
      r = is_c ? PORTC_REGS.dir : PORTB_REGS.dir;
      nopud = {8{~GLOBAL_PULLUP_OFF}};
      {pu_en, val_en, ie_en} = expect_enables(is_c);
      if (!is_c)
      begin
         dir_val = 8'h00;
         val = {periph[0], periph[2], periph[1], 1'b0, periph[4], 2'b00, periph[3]};
         ie_val = 8'h04;
         pu_val = d & nopud;
      end
      else
      begin
         dir_val = {3'b000, periph[5] | periph[6], 2'b00, periph[8], periph[9]};
         val = {3'b000, periph[7], 4'h0};
         ie_val = 8'h00;
         pu_val = {6'b001011, d[1:0] & nopud[1:0]};
      end
      dir = (pu_en & dir_val) | (~pu_en & r);
      return {(val_en & val) | (~val_en & d), ~dir, (pu_en & pu_val) | (~pu_en & ~r & d & nopud),
         (ie_en & ie_val) | (~ie_en & {8{~SLEEP_INPUT_OFF}})};
   endfunction

   // expected function-input taps on port b
   function automatic logic [7:0] expect_taps();
      logic [31:0] e;
      logic [7:0] p;
      e = expect_port(1'b0);
      p = PB_PAD_IN & e[7:0];
      return {p[7], p[6], p[5], p[4], p[2], p[1], p[0], p[0] & USART_SYNC_SELECT};
   endfunction

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
      begin
         $display("NO MISMATCHES");
      end
      else
      begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial
   begin
      logic [63:0] v;
      logic [23:0] en;
      int n;
      void'($urandom(32'h70d3ccae));
      repeat (10) @(negedge MCLK);
      check({PC_PULLUP[5], PC_PULLUP[3], PC_PULLUP[2]}, 3'b111, "test pull-ups");
      @(posedge MCLK);
      RSTN <= 1'b1;
      for (int i = 0; i < 150; i++)
      begin
         v = (i == 0) ? '1 : (i == 1) ? '0 : {$urandom, $urandom};
         @(posedge MCLK);
         {GLOBAL_PULLUP_OFF, SLEEP_INPUT_OFF, SERIAL_PERIPH_ON, MASTER_ROLE_BIT,
            USART_SYNC_SELECT, COMPARE_OUT_ZERO_EN, EXTERNAL_IRQ_TWO_EN, ASYNC_TIMER2_CLOCK,
            TEST_PORT_ENABLE, TWO_WIRE_ENABLE, PORTB_REGS, PORTC_REGS, PB_PAD_IN,
            PC_PAD_IN} <= v[57:0];
         @(negedge MCLK);
         check(pins_b, expect_port(1'b0), "port b");
         check(pins_c, expect_port(1'b1), "port c");
         en = expect_enables(1'b0);
         check(got_enables(pb_ovr), {en[23:16], en}, "port b enables");
         en = expect_enables(1'b1);
         check(got_enables(pc_ovr), {en[23:16], en}, "port c enables");
         repeat (2) @(negedge MCLK);
         check(taps, expect_taps(), "taps");
      end
      @(posedge MCLK);
      TWO_WIRE_ENABLE <= 1'b1;
      PC_PAD_IN <= 8'hff;
      repeat (12) @(negedge MCLK);
      check({SDA_TO_TWI, SCL_TO_TWI}, 2'b11, "two-wire idle");
      @(posedge MCLK);
      PC_PAD_IN[1:0] <= 2'b00;
      repeat (pbcao_pkg::SPIKE_CYC - 1) @(posedge MCLK);
      PC_PAD_IN[1:0] <= 2'b11;
      n = 0;
      repeat (16)
      begin
         @(negedge MCLK);
         n = n + int'(SDA_TO_TWI !== 1'b1) + int'(SCL_TO_TWI !== 1'b1);
      end
      check(n, 0, "short pulse passed");
      @(posedge MCLK);
      PC_PAD_IN[1:0] <= 2'b00;
      n = 0;
      while (SDA_TO_TWI === 1'b1 && n < 30)
      begin
         @(negedge MCLK);
         n++;
      end
      check({SDA_TO_TWI, SCL_TO_TWI}, 2'b00, "long pulse lost");
      check(n >= pbcao_pkg::SPIKE_CYC && n <= pbcao_pkg::SPIKE_CYC + 4, 1, "filter delay");
      print_verdict();
   end
endmodule
`default_nettype wire
